// ### core/tap_ctrl_regs.vh
`ifndef TAP_CTRL_REGS_VH
`define TAP_CTRL_REGS_VH

// controller states, binary coded
`define ST_RESET      4'h0
`define ST_IDLE       4'h1
`define ST_SEL_DR     4'h2
`define ST_CAP_DR     4'h3
`define ST_SHIFT_DR   4'h4
`define ST_EXIT1_DR   4'h5
`define ST_PAUSE_DR   4'h6
`define ST_EXIT2_DR   4'h7
`define ST_UPD_DR     4'h8
`define ST_SEL_IR     4'h9
`define ST_CAP_IR     4'hA
`define ST_SHIFT_IR   4'hB
`define ST_EXIT1_IR   4'hC
`define ST_PAUSE_IR   4'hD
`define ST_EXIT2_IR   4'hE
`define ST_UPD_IR     4'hF

// instruction codes
`define IR_W          3
`define INS_EXTEST    3'h0
`define INS_IDCODE    3'h1
`define INS_SAMPLE    3'h2
`define INS_CLAMP     3'h3
`define INS_BYPASS    3'h7
`define IR_CAPTURE    3'h4

// boundary chain, cells 1..36 (bit index = cell number - 1)
`define BSR_LEN       36
`define ID_LEN        32
// neutral identification value, arbitrary
`define ID_VALUE      32'h10000001

`endif

// ### core/tap_ctrl.v
// Function
// - controller has exactly sixteen states
// - transitions follow tms at rising tck
// - test-logic-reset keeps test logic disabled
// - entering reset loads identification instruction
// - five high tms edges force reset
// - stay in reset while tms high
// - idle holds on low, high goes select-dr
// - select-dr: low capture, high select-ir
// - capture boundary pins only for extest/sample
// - capture-dr: high exit1, low shift
// - shift-dr moves selected register toward tdo
// - exit1-dr: high update, low pause
// - pause-dr holds on low, high exit2
// - exit2-dr: high update, low shift
// - exit and pause states hold registers
// - chain cells 1, 4-7 observe inputs
// - update-dr latches outputs on falling tck, for extest/sample only
// - capture-ir loads fixed pattern 100
// - select-ir: low capture-ir, high reset
// - update-ir latches instruction on falling tck
`timescale 1ns/10ps
`include "tap_ctrl_regs.vh"

module tap_ctrl #(
  parameter BSR_LEN = `BSR_LEN
) (
  input wire clk_sys,
  input wire nrst,
  input wire tck,
  input wire tms,
  input wire tdi,
  output reg tdo,
  output reg tdo_oe_n,
  input wire [BSR_LEN-1:0] bsr_pins_in,
  input wire oscillator_input,
  input wire [2:0] clk_sel_in,
  input wire reset_pin_in,
  output reg [BSR_LEN-1:0] bsr_out,
  output reg [`IR_W-1:0] instr,
  output wire test_logic_en,
  output reg [3:0] tap_state
);

  // link inputs cross into clk_sys before anything looks at them
  reg [2:0] sync1_reg;
  reg [2:0] sync2_reg;
  reg tck_prev_reg;
  always @(posedge clk_sys) begin
    if (!nrst) begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
      tck_prev_reg <= 1'b0;
    end else begin
      sync1_reg <= {tck, tms, tdi};
      sync2_reg <= sync1_reg;
      tck_prev_reg <= sync2_reg[2];
    end
  end
  wire tck_s = sync2_reg[2];
  wire tms_s = sync2_reg[1];
  wire tdi_s = sync2_reg[0];
  wire tck_rise = tck_s & ~tck_prev_reg;
  wire tck_fall = ~tck_s & tck_prev_reg;

  reg [3:0] state_next;
  reg [`IR_W-1:0] ir_sh_reg;
  reg [BSR_LEN-1:0] bsr_sh_reg;
  reg [`ID_LEN-1:0] id_sh_reg;
  reg byp_reg;

  // observed pins are asynchronous too; two flops before capture
  reg [BSR_LEN-1:0] pins_s1_reg;
  reg [BSR_LEN-1:0] pins_s2_reg;
  reg [4:0] fixed_s1_reg;
  reg [4:0] fixed_s2_reg;
  always @(posedge clk_sys) begin
    if (!nrst) begin
      pins_s1_reg <= {BSR_LEN{1'b0}};
      pins_s2_reg <= {BSR_LEN{1'b0}};
      fixed_s1_reg <= 5'h00;
      fixed_s2_reg <= 5'h00;
    end else begin
      pins_s1_reg <= bsr_pins_in;
      pins_s2_reg <= pins_s1_reg;
      fixed_s1_reg <= {reset_pin_in, clk_sel_in, oscillator_input};
      fixed_s2_reg <= fixed_s1_reg;
    end
  end

  // cells 1 and 4..7 observe fixed inputs; others come from the pin vector
  reg [BSR_LEN-1:0] bsr_capture;
  always @* begin
    bsr_capture = pins_s2_reg;
    bsr_capture[0] = fixed_s2_reg[0];
    bsr_capture[3] = fixed_s2_reg[3];
    bsr_capture[4] = fixed_s2_reg[2];
    bsr_capture[5] = fixed_s2_reg[1];
    bsr_capture[6] = fixed_s2_reg[4];
  end

  function bsr_selected;
    input [`IR_W-1:0] ins;
    begin
      bsr_selected = (ins == `INS_EXTEST) || (ins == `INS_SAMPLE);
    end
  endfunction

  // sixteen-state next-state table
  always @* begin
    case (tap_state)
      `ST_RESET: state_next = tms_s ? `ST_RESET : `ST_IDLE;
      `ST_IDLE: state_next = tms_s ? `ST_SEL_DR : `ST_IDLE;
      `ST_SEL_DR: state_next = tms_s ? `ST_SEL_IR : `ST_CAP_DR;
      `ST_CAP_DR: state_next = tms_s ? `ST_EXIT1_DR : `ST_SHIFT_DR;
      `ST_SHIFT_DR: state_next = tms_s ? `ST_EXIT1_DR : `ST_SHIFT_DR;
      `ST_EXIT1_DR: state_next = tms_s ? `ST_UPD_DR : `ST_PAUSE_DR;
      `ST_PAUSE_DR: state_next = tms_s ? `ST_EXIT2_DR : `ST_PAUSE_DR;
      `ST_EXIT2_DR: state_next = tms_s ? `ST_UPD_DR : `ST_SHIFT_DR;
      `ST_UPD_DR: state_next = tms_s ? `ST_SEL_DR : `ST_IDLE;
      `ST_SEL_IR: state_next = tms_s ? `ST_RESET : `ST_CAP_IR;
      `ST_CAP_IR: state_next = tms_s ? `ST_EXIT1_IR : `ST_SHIFT_IR;
      `ST_SHIFT_IR: state_next = tms_s ? `ST_EXIT1_IR : `ST_SHIFT_IR;
      `ST_EXIT1_IR: state_next = tms_s ? `ST_UPD_IR : `ST_PAUSE_IR;
      `ST_PAUSE_IR: state_next = tms_s ? `ST_EXIT2_IR : `ST_PAUSE_IR;
      `ST_EXIT2_IR: state_next = tms_s ? `ST_UPD_IR : `ST_SHIFT_IR;
      `ST_UPD_IR: state_next = tms_s ? `ST_SEL_DR : `ST_IDLE;
      default: state_next = `ST_RESET;
    endcase
  end

  // five high edges always land in reset: every path reaches it within five
  always @(posedge clk_sys) begin
    if (!nrst) begin
      tap_state <= `ST_RESET;
    end else if (tck_rise) begin
      tap_state <= state_next;
    end
  end

  // rising-edge work: capture and shift; other states leave registers alone
  always @(posedge clk_sys) begin
    if (!nrst) begin
      ir_sh_reg <= `INS_IDCODE;
      bsr_sh_reg <= {BSR_LEN{1'b0}};
      id_sh_reg <= `ID_VALUE;
      byp_reg <= 1'b0;
    end else if (tck_rise) begin
      case (tap_state)
        `ST_CAP_DR: begin
          if (bsr_selected(instr)) begin
            bsr_sh_reg <= bsr_capture;
          end
          if (instr == `INS_IDCODE) begin
            id_sh_reg <= `ID_VALUE;
          end
          byp_reg <= 1'b0;
        end
        `ST_SHIFT_DR: begin
          if (bsr_selected(instr)) begin
            bsr_sh_reg <= {tdi_s, bsr_sh_reg[BSR_LEN-1:1]};
          end else if (instr == `INS_IDCODE) begin
            id_sh_reg <= {tdi_s, id_sh_reg[`ID_LEN-1:1]};
          end else begin
            byp_reg <= tdi_s;
          end
        end
        `ST_CAP_IR: ir_sh_reg <= `IR_CAPTURE;
        `ST_SHIFT_IR: ir_sh_reg <= {tdi_s, ir_sh_reg[`IR_W-1:1]};
        default: ir_sh_reg <= ir_sh_reg;
      endcase
    end
  end

  // serial output of the register currently in the path
  reg tdo_next;
  always @* begin
    if (tap_state == `ST_SHIFT_IR) begin
      tdo_next = ir_sh_reg[0];
    end else if (bsr_selected(instr)) begin
      tdo_next = bsr_sh_reg[0];
    end else if (instr == `INS_IDCODE) begin
      tdo_next = id_sh_reg[0];
    end else begin
      tdo_next = byp_reg;
    end
  end

  // falling-edge work: updates and tdo
  always @(posedge clk_sys) begin
    if (!nrst) begin
      instr <= `INS_IDCODE;
      bsr_out <= {BSR_LEN{1'b0}};
      tdo <= 1'b0;
      tdo_oe_n <= 1'b1;
    end else if (tap_state == `ST_RESET) begin
      instr <= `INS_IDCODE;
      tdo_oe_n <= 1'b1;
    end else if (tck_fall) begin
      if (tap_state == `ST_UPD_DR && bsr_selected(instr)) begin
        bsr_out <= bsr_sh_reg;
      end
      if (tap_state == `ST_UPD_IR) begin
        instr <= ir_sh_reg;
      end
      // released except while a register is being shifted out
      tdo <= tdo_next;
      tdo_oe_n <= ~((tap_state == `ST_SHIFT_DR) || (tap_state == `ST_SHIFT_IR));
    end
  end

  // test logic inactive in reset, functional pins untouched
  assign test_logic_en = (tap_state != `ST_RESET);

endmodule // tap_ctrl

// ### dv/tap_ctrl_sva.sv
`timescale 1ns/10ps
`include "tap_ctrl_regs.vh"
module tap_ctrl_sva #(
  parameter BSR_LEN = 36
) (
  input wire clk_sys,
  input wire nrst,
  input wire tdo_oe_n,
  input wire [BSR_LEN-1:0] bsr_out,
  input wire [2:0] instr,
  input wire test_logic_en,
  input wire [3:0] tap_state
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  reg [3:0] prev;
  always @(posedge clk_sys) prev <= tap_state;
  wire moved = tap_state != prev;
  a_reset_quiet: assert property (test_logic_en == (tap_state != `ST_RESET))
    else $error("test logic on in reset");
  a_reset_instr: assert property ((tap_state == `ST_RESET)[*2] |-> instr == `INS_IDCODE)
    else $error("no idcode in reset");
  a_idle_exit: assert property (moved && prev == `ST_IDLE |-> tap_state == `ST_SEL_DR)
    else $error("bad idle exit");
  a_seldr_exit: assert property (moved && prev == `ST_SEL_DR |->
    tap_state == `ST_CAP_DR || tap_state == `ST_SEL_IR) else $error("bad select exit");
  a_capdr_exit: assert property (moved && prev == `ST_CAP_DR |->
    tap_state == `ST_EXIT1_DR || tap_state == `ST_SHIFT_DR) else $error("bad capture exit");
  a_pause_exit: assert property (moved && prev == `ST_PAUSE_DR |-> tap_state == `ST_EXIT2_DR)
    else $error("bad pause exit");
  a_bsr_latch: assert property ($changed(bsr_out) |-> tap_state == `ST_UPD_DR)
    else $error("outputs moved outside update");
  a_instr_hold: assert property ($changed(instr) |->
    tap_state == `ST_UPD_IR || tap_state == `ST_RESET) else $error("instruction moved");
  a_oe_shift: assert property ($fell(tdo_oe_n) |->
    tap_state == `ST_SHIFT_DR || tap_state == `ST_SHIFT_IR) else $error("tdo driven off shift");
endmodule // tap_ctrl_sva
bind tap_ctrl tap_ctrl_sva #(.BSR_LEN(BSR_LEN)) tap_ctrl_sva_inst (.clk_sys(clk_sys),
  .nrst(nrst), .tdo_oe_n(tdo_oe_n), .bsr_out(bsr_out), .instr(instr),
  .test_logic_en(test_logic_en), .tap_state(tap_state));

// ### dv/tap_tester.sv
`timescale 1ns/10ps
module tap_tester (
  input wire clk_sys,
  input wire tdo,
  output reg tck,
  output reg tms,
  output reg tdi,
  output reg tdo_seen
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    tdo_seen = 1'b0;
  end
  // 44 ns period; tms set a whole low phase ahead of the rise
  task step(input t, input d);
    begin
      @(posedge clk_sys);
      tck <= 1'b0;
      tms <= t;
      tdi <= d;
      repeat (5) @(posedge clk_sys);
      tdo_seen <= tdo;
      tck <= 1'b1;
      repeat (5) @(posedge clk_sys);
    end
  endtask
endmodule // tap_tester

// ### dv/tap_ctrl_bench.sv
`timescale 1ns/10ps
`include "tap_ctrl_regs.vh"
module tap_ctrl_bench;
  reg clk_sys = 1'b0;
  reg nrst = 1'b0;
  reg osc = 1'b0;
  reg rst_pin = 1'b0;
  reg [2:0] sel = 3'h0;
  reg [35:0] pins = 36'h0;
  reg [35:0] got;
  wire tck, tms, tdi, tdo, tdo_oe_n, tdo_seen, test_logic_en;
  wire [35:0] bsr_out;
  wire [2:0] instr;
  wire [3:0] tap_state;
  integer n_fail = 0;
  integer total_checks = 0;
  integer cycles = 0;
  tap_tester tap_tester_inst (.clk_sys(clk_sys), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo_seen(tdo_seen));
  tap_ctrl tap_ctrl_inst (.clk_sys(clk_sys), .nrst(nrst), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdo_oe_n(tdo_oe_n), .bsr_pins_in(pins), .oscillator_input(osc),
    .clk_sel_in(sel), .reset_pin_in(rst_pin), .bsr_out(bsr_out), .instr(instr),
    .test_logic_en(test_logic_en), .tap_state(tap_state));
  task check(input [39:0] seen, input [39:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("CHECK FAILED %0t: saw %h want %h", $time, seen, exp);
      end
    end
  endtask
  task walk(input [7:0] seq, input integer n);
    integer i;
    for (i = 0; i < n; i = i + 1) tap_tester_inst.step(seq[i], 1'b0);
  endtask
  // tdo seen before each rise, so bit i is the i-th bit out
  task scan(input integer n, input last, input [35:0] din);
    integer i;
    for (i = 0; i < n; i = i + 1) begin
      tap_tester_inst.step((i == n - 1) ? last : 1'b0, din[i]);
      got[i] = tap_tester_inst.tdo_seen;
    end
  endtask
  task t_id_reset;
    begin
      walk(8'h02, 4);
      got = 36'h0;
      scan(32, 1'b0, 36'h0);
      check(got, {4'h0, `ID_VALUE});
      check({tdo_oe_n, tap_state}, {1'b0, `ST_SHIFT_DR});
      walk(8'h1F, 5);
      check({instr, tap_state}, {`INS_IDCODE, `ST_RESET});
      walk(8'h07, 3);
      check({test_logic_en, tap_state}, {1'b0, `ST_RESET});
    end
  endtask
  task t_ir_load;
    begin
      walk(8'h06, 5);
      scan(3, 1'b1, {33'h0, `INS_EXTEST});
      check(got[2:0], `IR_CAPTURE);
      walk(8'h01, 2);
      check({instr, tap_state}, {`INS_EXTEST, `ST_IDLE});
    end
  endtask
  task t_boundary;
    begin
      pins <= 36'h5A5A5A5A5;
      sel <= 3'h6;
      rst_pin <= 1'b1;
      walk(8'h01, 3);
      scan(36, 1'b1, 36'h93C3C3C3C);
      check(got, {pins[35:7], rst_pin, sel[0], sel[1], sel[2], pins[2:1], osc});
      walk(8'h00, 2);
      check({bsr_out, tap_state}, {36'h0, `ST_PAUSE_DR});
      walk(8'h03, 3);
      check({bsr_out, tdo_oe_n}, {36'h93C3C3C3C, 1'b1});
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d failures %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_fail = n_fail + 1;
      tally_and_finish;
    end
  end
  initial begin
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    t_id_reset;
    t_ir_load;
    t_boundary;
    tally_and_finish;
  end
endmodule // tap_ctrl_bench
